// *** src/smart_card_pin_control.sv ***
// Card-side control of a smart card coupler: presence, reset, clock, serial path, faults.
// Assumes every host, card and monitor input is asynchronous; no register bus.
`timescale 1ns/1ps
module smart_card_pin_control
	import card_pkg::*;
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic sys_rst,
	// Host control pins
	input  wire logic chip_select_n,
	input  wire logic power_request,
	input  wire logic program_select_n,
	input  wire logic program_addr_bit0,
	input  wire logic program_addr_bit1,
	input  wire logic host_reset_in,
	input  wire logic source_clock_in,
	// Host serial pin, open drain
	input  wire logic host_serial_i,
	output logic      host_serial_o,
	output logic      host_serial_oe,
	// Card connector
	input  wire logic card_presence_in,
	input  wire logic card_serial_line_i,
	output logic      card_serial_line_o,
	output logic      card_serial_line_oe,
	output logic      card_reset_out,
	output logic      card_clock_out,
	// Supply monitors
	input  wire logic card_supply_low_in,
	input  wire logic card_supply_overload_in,
	input  wire logic battery_low_in,
	// Status to host and converter
	output logic      interrupt_n_out,
	output logic      status_out,
	output logic      converter_enable_out,
	output logic      card_power_down_sequence
);
	card_ctl_if ctl ();

	logic [PIN_COUNT-1:0] pins_raw;
	logic [PIN_COUNT-1:0] pins_meta_q;
	logic [PIN_COUNT-1:0] pins_q;
	logic [PIN_COUNT-1:0] prev_q;

	power_state_t         state_q;
	power_state_t         state_d;
	logic [PD_CNT_W-1:0]  step_cnt_q;
	logic                 step_done;

	logic       presence_nc_q;
	logic [1:0] div_code_q;
	logic       park_en_q;
	logic       park_high_q;
	logic [1:0] status_sel_q;
	logic       overload_fault_q;
	logic       int_n_q;
	logic       serial_hold_q;
	logic       card_drive_q;
	logic       host_drive_q;
	logic [GUARD_W-1:0] card_hist_q;
	logic [GUARD_W-1:0] host_hist_q;
	logic       card_reset_q;
	logic       status_q;
	logic       pd_seq_q;
	logic       conv_en_q;

	logic cs_low;
	logic cs_rise;
	logic pwr_rise;
	logic pwr_fall;
	logic prog_strobe;
	logic bat_low;
	logic overload;
	logic io_powered;

	// Synchroniser reset matches the idle pin levels, so no false edge follows reset
	localparam logic [PIN_COUNT-1:0] PINS_IDLE = PIN_COUNT'((1 << PIN_CS_N) | (1 << PIN_PGM_N)
		| (1 << PIN_HOST_SER) | (1 << PIN_CARD_SER));

	// ****************************************
	// Input synchronisers
	// ****************************************
	assign pins_raw = {battery_low_in, card_supply_overload_in, card_supply_low_in,
		card_serial_line_i, host_serial_i, host_reset_in, program_addr_bit1,
		program_addr_bit0, program_select_n, power_request, chip_select_n};

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pins_meta_q <= PINS_IDLE;
			pins_q      <= PINS_IDLE;
			prev_q      <= PINS_IDLE;
		end else begin
			pins_meta_q <= pins_raw;
			pins_q      <= pins_meta_q;
			prev_q      <= pins_q;
		end
	end

	assign cs_low   = ~pins_q[PIN_CS_N];
	assign cs_rise  = rose(prev_q[PIN_CS_N], pins_q[PIN_CS_N]);
	assign bat_low  = pins_q[PIN_BAT_LOW];
	assign overload = pins_q[PIN_OVERLOAD];
	// Power request edges only count for power sequencing and fault clearing while chip select is low
	assign pwr_rise = cs_low & rose(prev_q[PIN_PWR_REQ], pins_q[PIN_PWR_REQ]);
	assign pwr_fall = cs_low & fell(prev_q[PIN_PWR_REQ], pins_q[PIN_PWR_REQ]);
	// prev_q still holds the levels seen while chip select was low
	assign prog_strobe = cs_rise & ~prev_q[PIN_PGM_N] & ~bat_low;

	// ****************************************
	// Programming registers
	// ****************************************
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			presence_nc_q <= PRESENCE_NC_RST;
			div_code_q    <= DIV_RESET;
			park_en_q     <= 1'b0;
			park_high_q   <= 1'b0;
			status_sel_q  <= SEL_RESET;
		end else if (prog_strobe) begin
			case ({prev_q[PIN_ADDR1], prev_q[PIN_ADDR0]})
				ADDR_CLOCK_DIV: begin
					div_code_q <= {prev_q[PIN_HOST_RST], prev_q[PIN_HOST_SER]};
				end
				ADDR_CLOCK_PARK: begin
					park_en_q   <= prev_q[PIN_HOST_SER];
					park_high_q <= prev_q[PIN_HOST_RST];
				end
				ADDR_PRESENCE: begin
					presence_nc_q <= prev_q[PIN_HOST_SER];
				end
				default: begin
					status_sel_q <= {prev_q[PIN_HOST_RST], prev_q[PIN_HOST_SER]};
				end
			endcase
		end
	end

	// ****************************************
	// Card power sequencing
	// ****************************************
	assign step_done = (step_cnt_q == PD_CNT_W'(PD_STEP_CYCLES - 1));

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_OFF: begin
				if (pwr_rise && !bat_low && !overload) begin
					state_d = ST_ACTIVE;
				end
			end
			ST_ACTIVE: begin
				if (overload) begin
					state_d = ST_OFF;
				end else if (bat_low || pwr_fall) begin
					state_d = ST_DROP_RESET;
				end
			end
			ST_DROP_RESET:  state_d = step_done ? ST_STOP_CLOCK : ST_DROP_RESET;
			ST_STOP_CLOCK:  state_d = step_done ? ST_DROP_SERIAL : ST_STOP_CLOCK;
			ST_DROP_SERIAL: state_d = step_done ? ST_OFF : ST_DROP_SERIAL;
			default:        state_d = ST_OFF;
		endcase
		if (overload && state_q != ST_OFF) begin
			state_d = ST_OFF;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_q    <= ST_OFF;
			step_cnt_q <= '0;
		end else begin
			state_q    <= state_d;
			step_cnt_q <= (state_d != state_q || step_done) ? '0 : step_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			conv_en_q <= 1'b0;
			pd_seq_q  <= 1'b0;
		end else begin
			conv_en_q <= (state_d != ST_OFF);
			pd_seq_q  <= (state_d == ST_DROP_RESET) || (state_d == ST_STOP_CLOCK)
				|| (state_d == ST_DROP_SERIAL);
		end
	end

	// ****************************************
	// Card reset
	// ****************************************
	always_ff @(posedge clock) begin
		if (sys_rst || state_q != ST_ACTIVE) begin
			card_reset_q <= 1'b0;
		end else if (cs_low && pins_q[PIN_PGM_N] && pins_q[PIN_PWR_REQ]) begin
			card_reset_q <= pins_q[PIN_HOST_RST];
		end
	end

	// ****************************************
	// Serial path
	// ****************************************
	// Both ends are open drain; our own drive echoes back through the
	// synchroniser, so the history guard stops the two sides locking low.
	assign io_powered = (state_q == ST_ACTIVE) || (state_q == ST_DROP_RESET)
		|| (state_q == ST_STOP_CLOCK);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			serial_hold_q <= 1'b1;
		end else if (cs_low) begin
			serial_hold_q <= pins_q[PIN_HOST_SER];
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			card_drive_q <= 1'b0;
			host_drive_q <= 1'b0;
			card_hist_q  <= '0;
			host_hist_q  <= '0;
		end else begin
			card_hist_q <= {card_hist_q[GUARD_W-2:0], card_drive_q};
			host_hist_q <= {host_hist_q[GUARD_W-2:0], host_drive_q};
			if (state_q == ST_DROP_SERIAL) begin
				card_drive_q <= 1'b1;
				host_drive_q <= 1'b0;
			end else if (!io_powered) begin
				card_drive_q <= 1'b0;
				host_drive_q <= 1'b0;
			end else if (cs_low) begin
				card_drive_q <= ~pins_q[PIN_HOST_SER] & ~host_drive_q & ~|host_hist_q;
				host_drive_q <= ~pins_q[PIN_CARD_SER] & ~card_drive_q & ~|card_hist_q;
			end else begin
				card_drive_q <= ~serial_hold_q;
				host_drive_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Faults, interrupt and status
	// ****************************************
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			overload_fault_q <= 1'b0;
		end else if (overload && state_q != ST_OFF) begin
			overload_fault_q <= 1'b1;
		end else if (pwr_rise) begin
			overload_fault_q <= 1'b0;
		end
	end

	// A new event in the clearing cycle keeps the interrupt asserted
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			int_n_q <= 1'b1;
		end else if (ctl.insert_pulse || (overload && state_q != ST_OFF)
			|| rose(prev_q[PIN_SUP_LOW], pins_q[PIN_SUP_LOW])
			|| rose(prev_q[PIN_BAT_LOW], bat_low)) begin
			int_n_q <= 1'b0;
		end else if (cs_rise || rose(prev_q[PIN_PWR_REQ], pins_q[PIN_PWR_REQ])) begin
			int_n_q <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			status_q <= 1'b0;
		end else if (bat_low) begin
			status_q <= 1'b0;
		end else begin
			case (status_sel_q)
				SEL_PRESENCE:  status_q <= ctl.present;
				SEL_BATTERY:   status_q <= 1'b1;
				SEL_CONVERTER: status_q <= conv_en_q & ~overload_fault_q;
				SEL_SUPPLY:    status_q <= ~pins_q[PIN_SUP_LOW];
				default:       status_q <= 1'b0;
			endcase
		end
	end

	// ****************************************
	// Helpers and outputs
	// ****************************************
	assign ctl.presence_nc = presence_nc_q;
	assign ctl.div_code    = div_code_q;
	assign ctl.park_en     = park_en_q;
	assign ctl.park_high   = park_high_q;
	assign ctl.clock_run   = (state_q == ST_ACTIVE) || (state_q == ST_DROP_RESET);

	presence_detect u_presence (
		.clock            (clock),
		.sys_rst          (sys_rst),
		.card_presence_in (card_presence_in),
		.ctl              (ctl.presence)
	);

	clock_selector u_selector (
		.clock           (clock),
		.sys_rst         (sys_rst),
		.source_clock_in (source_clock_in),
		.ctl             (ctl.selector)
	);

	assign card_reset_out           = card_reset_q;
	assign card_clock_out           = ctl.card_clock;
	assign card_serial_line_o       = 1'b0;
	assign card_serial_line_oe      = card_drive_q;
	assign host_serial_o            = 1'b0;
	assign host_serial_oe           = host_drive_q;
	assign interrupt_n_out          = int_n_q;
	assign status_out               = status_q;
	assign converter_enable_out     = conv_en_q;
	assign card_power_down_sequence = pd_seq_q;

	reset_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
		(state_q == ST_ACTIVE && cs_low && pins_q[PIN_PGM_N] && pins_q[PIN_PWR_REQ]
			&& state_d == ST_ACTIVE) |=> card_reset_out == $past(pins_q[PIN_HOST_RST]))
		else $error("card reset did not follow host reset");

	reset_idle_a: assert property (@(posedge clock) disable iff (sys_rst)
		(state_q != ST_ACTIVE) |=> !card_reset_out)
		else $error("card reset high while deactivated");

	overload_off_a: assert property (@(posedge clock) disable iff (sys_rst)
		(overload && state_q != ST_OFF) |=> (!converter_enable_out && !interrupt_n_out))
		else $error("overload did not stop converter and raise interrupt");

	battery_down_a: assert property (@(posedge clock) disable iff (sys_rst)
		(bat_low && state_q == ST_ACTIVE && !overload) |=> card_power_down_sequence && !status_out
			##1 (card_power_down_sequence && !status_out) [*2])
		else $error("low battery did not start power-down");

	int_release_a: assert property (@(posedge clock) disable iff (sys_rst)
		(cs_rise && !ctl.insert_pulse && !overload && !rose(prev_q[PIN_SUP_LOW],
			pins_q[PIN_SUP_LOW]) && !rose(prev_q[PIN_BAT_LOW], bat_low)) |=> interrupt_n_out)
		else $error("interrupt not released on chip select rise");

	prog_ignore_a: assert property (@(posedge clock) disable iff (sys_rst)
		!cs_rise |=> $stable(div_code_q) && $stable(presence_nc_q))
		else $error("programming changed outside chip select edge");

	serial_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
		!cs_low |=> $stable(serial_hold_q))
		else $error("held serial level changed with chip select high");

	undervolt_only_a: assert property (@(posedge clock) disable iff (sys_rst)
		(pins_q[PIN_SUP_LOW] && !overload && !bat_low && !pwr_fall && state_q == ST_ACTIVE)
			|=> state_q == ST_ACTIVE)
		else $error("undervoltage changed power state");
endmodule : smart_card_pin_control

// *** src/card_pkg.sv ***
// Shared constants, state codes and helper functions of the card pin control.
// Assumes one 125 MHz clock; some figures below are used by more than one file.
package card_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLOCK_MHZ      = 125;
	localparam int PD_STEP_NS     = 1000;
	// Least time per power-down step, rounded up to whole cycles
	localparam int PD_STEP_CYCLES = (PD_STEP_NS * CLOCK_MHZ + 999) / 1000;
	localparam int PD_CNT_W       = $clog2(PD_STEP_CYCLES + 1);
	localparam int GUARD_W        = 3;

	// ****************************************
	// Programming addresses and codes
	// ****************************************
	localparam logic [1:0] ADDR_CLOCK_DIV  = 2'h0;
	localparam logic [1:0] ADDR_CLOCK_PARK = 2'h1;
	localparam logic [1:0] ADDR_PRESENCE   = 2'h2;
	localparam logic [1:0] ADDR_STATUS_SEL = 2'h3;

	localparam logic [1:0] DIV_1 = 2'h0;
	localparam logic [1:0] DIV_2 = 2'h1;
	localparam logic [1:0] DIV_4 = 2'h2;
	localparam logic [1:0] DIV_8 = 2'h3;

	localparam logic [1:0] SEL_PRESENCE  = 2'h0;
	localparam logic [1:0] SEL_BATTERY   = 2'h1;
	localparam logic [1:0] SEL_CONVERTER = 2'h2;
	localparam logic [1:0] SEL_SUPPLY    = 2'h3;

	// Reset values
	localparam logic [1:0] DIV_RESET        = DIV_1;
	localparam logic [1:0] SEL_RESET        = SEL_PRESENCE;
	localparam logic       PRESENCE_NC_RST  = 1'b0;

	// ****************************************
	// Pin vector layout after synchronisation
	// ****************************************
	localparam int PIN_CS_N     = 0;
	localparam int PIN_PWR_REQ  = 1;
	localparam int PIN_PGM_N    = 2;
	localparam int PIN_ADDR0    = 3;
	localparam int PIN_ADDR1    = 4;
	localparam int PIN_HOST_RST = 5;
	localparam int PIN_HOST_SER = 6;
	localparam int PIN_CARD_SER = 7;
	localparam int PIN_SUP_LOW  = 8;
	localparam int PIN_OVERLOAD = 9;
	localparam int PIN_BAT_LOW  = 10;
	localparam int PIN_COUNT    = 11;

	typedef enum logic [2:0] {
		ST_OFF         = 3'b000,
		ST_ACTIVE      = 3'b001,
		ST_DROP_RESET  = 3'b010,
		ST_STOP_CLOCK  = 3'b011,
		ST_DROP_SERIAL = 3'b100
	} power_state_t;

	function automatic logic rose(input logic prev, input logic cur);
		return cur & ~prev;
	endfunction : rose

	function automatic logic fell(input logic prev, input logic cur);
		return prev & ~cur;
	endfunction : fell

endpackage : card_pkg

// *** src/card_ctl_if.sv ***
// Settings and results passed between the control core and its two helpers.
// Assumes all three run on the same clock.
`timescale 1ns/1ps
interface card_ctl_if;
	logic       presence_nc;
	logic       insert_pulse;
	logic       present;
	logic [1:0] div_code;
	logic       park_en;
	logic       park_high;
	logic       clock_run;
	logic       card_clock;

	modport ctl (output presence_nc, div_code, park_en, park_high, clock_run,
		input insert_pulse, present, card_clock);
	modport presence (input presence_nc, output insert_pulse, present);
	modport selector (input div_code, park_en, park_high, clock_run, output card_clock);
endinterface : card_ctl_if

// *** src/presence_detect.sv ***
// Card presence switch: synchroniser, polarity and insertion edge.
// Assumes the presence pin is asynchronous and held by a weak pull-up outside.
`timescale 1ns/1ps
module presence_detect
	import card_pkg::*;
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic sys_rst,
	// Pin and control
	input  wire logic card_presence_in,
	card_ctl_if.presence ctl
);
	logic meta_q;
	logic level_q;
	logic prev_q;
	logic pulse_q;
	logic present_q;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			meta_q  <= 1'b1;
			level_q <= 1'b1;
			prev_q  <= 1'b1;
		end else begin
			meta_q  <= card_presence_in;
			level_q <= meta_q;
			prev_q  <= level_q;
		end
	end

	// Open switch idles high, so insertion falls; closed switch rises
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pulse_q   <= 1'b0;
			present_q <= 1'b0;
		end else begin
			pulse_q   <= ctl.presence_nc ? rose(prev_q, level_q) : fell(prev_q, level_q);
			present_q <= ctl.presence_nc ? level_q : ~level_q;
		end
	end

	assign ctl.insert_pulse = pulse_q;
	assign ctl.present      = present_q;

	single_insert_a: assert property (@(posedge clock) disable iff (sys_rst)
		pulse_q |=> !pulse_q)
		else $error("insertion pulse lasted more than one cycle");

	open_polarity_a: assert property (@(posedge clock) disable iff (sys_rst)
		(!ctl.presence_nc && $past(!ctl.presence_nc) && fell(prev_q, level_q)) |=> pulse_q)
		else $error("falling presence edge missed in open switch mode");
endmodule : presence_detect

// *** src/clock_selector.sv ***
// Card clock selector: source clock undivided or divided by 2, 4 or 8, with park levels.
// Assumes the source clock is slower than a quarter of the system clock.
`timescale 1ns/1ps
module clock_selector
	import card_pkg::*;
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic sys_rst,
	// Source clock pin
	input  wire logic source_clock_in,
	card_ctl_if.selector ctl
);
	logic       meta_q;
	logic       src_q;
	logic       src_prev_q;
	logic [1:0] edge_cnt_q;
	logic       div_q;
	logic       out_q;
	logic [1:0] mask;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			meta_q     <= 1'b0;
			src_q      <= 1'b0;
			src_prev_q <= 1'b0;
		end else begin
			meta_q     <= source_clock_in;
			src_q      <= meta_q;
			src_prev_q <= src_q;
		end
	end

	always_comb begin
		case (ctl.div_code)
			DIV_4:   mask = 2'h1;
			DIV_8:   mask = 2'h3;
			default: mask = 2'h0;
		endcase
	end

	// Divided clock toggles every 1, 2 or 4 source rising edges
	always_ff @(posedge clock) begin
		if (sys_rst || !ctl.clock_run) begin
			edge_cnt_q <= 2'h0;
			div_q      <= 1'b0;
		end else if (rose(src_prev_q, src_q)) begin
			edge_cnt_q <= ((edge_cnt_q & mask) == mask) ? 2'h0 : edge_cnt_q + 2'h1;
			if ((edge_cnt_q & mask) == mask) begin
				div_q <= ~div_q;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst || !ctl.clock_run) begin
			out_q <= 1'b0;
		end else if (ctl.park_en) begin
			out_q <= ctl.park_high;
		end else begin
			out_q <= (ctl.div_code == DIV_1) ? src_q : div_q;
		end
	end

	assign ctl.card_clock = out_q;

	park_level_a: assert property (@(posedge clock) disable iff (sys_rst)
		(ctl.clock_run && ctl.park_en) [*2] |-> out_q == $past(ctl.park_high))
		else $error("parked card clock at wrong level");

	half_rate_a: assert property (@(posedge clock) disable iff (sys_rst)
		(ctl.clock_run && !ctl.park_en && ctl.div_code == DIV_2 && $stable(ctl.div_code)
			&& rose(src_prev_q, src_q)) |=> div_q != $past(div_q))
		else $error("divide by two missed a toggle");
endmodule : clock_selector

// *** test/card_model.sv ***
// Smart card seen at the connector: presence switch and serial line.
// Assumes pull-ups on the switch pin and on the card serial line.
`timescale 1ns/1ps
module card_model (
	// Bench control
	input  wire logic inserted,
	input  wire logic closed_switch,
	input  wire logic card_tx_low,
	// Connector
	input  wire logic card_serial_line_o,
	input  wire logic card_serial_line_oe,
	output logic      card_presence_in,
	output logic      card_serial_line_i
);
	// Open switch grounds the pin on insertion; a closed one opens and the pull-up wins
	assign card_presence_in   = closed_switch ? inserted : ~inserted;
	// Wired-AND line: released by both sides it floats back to the pull-up level
	assign card_serial_line_i = ~card_tx_low & ~(card_serial_line_oe & ~card_serial_line_o);
endmodule : card_model

// *** test/smart_card_pin_control_tb_top.sv ***
// Self-checking bench of the card pin control with a card model on the connector.
// Assumes the 125 MHz system clock and a slow source clock made here.
`timescale 1ns/1ps
module smart_card_pin_control_tb_top;
	import card_pkg::*;
	logic clock = 1'b0, sys_rst = 1'b1, chip_select_n = 1'b1, power_request = 1'b0;
	logic program_select_n = 1'b1, program_addr_bit0 = 1'b0, program_addr_bit1 = 1'b0;
	logic host_reset_in = 1'b0, source_clock_in = 1'b0, host_drv = 1'b1;
	logic card_supply_low_in = 1'b0, card_supply_overload_in = 1'b0, battery_low_in = 1'b0;
	logic inserted = 1'b0, closed_switch = 1'b0, card_tx_low = 1'b0;
	logic host_serial_i, host_serial_o, host_serial_oe, card_presence_in, card_serial_line_i;
	logic card_serial_line_o, card_serial_line_oe, card_reset_out, card_clock_out;
	logic interrupt_n_out, status_out, converter_enable_out, card_power_down_sequence;
	logic [2:0] src_cnt = 3'h0;
	int n_fail = 0, cmp_count = 0;

	always #4 clock = ~clock;
	// Host line has a pull-up; the device may pull it low
	assign host_serial_i = host_drv & ~(host_serial_oe & ~host_serial_o);
	// Source clock period of 12 system cycles, well below the selector limit
	always @(posedge clock) begin
		src_cnt <= (src_cnt == 3'h5) ? 3'h0 : src_cnt + 3'h1;
		if (src_cnt == 3'h5) source_clock_in <= ~source_clock_in;
	end

	smart_card_pin_control i_dut (.clock, .sys_rst, .chip_select_n, .power_request,
		.program_select_n, .program_addr_bit0, .program_addr_bit1, .host_reset_in,
		.source_clock_in, .host_serial_i, .host_serial_o, .host_serial_oe, .card_presence_in,
		.card_serial_line_i, .card_serial_line_o, .card_serial_line_oe, .card_reset_out,
		.card_clock_out, .card_supply_low_in, .card_supply_overload_in, .battery_low_in,
		.interrupt_n_out, .status_out, .converter_enable_out, .card_power_down_sequence);
	card_model i_card (.inserted, .closed_switch, .card_tx_low, .card_serial_line_o,
		.card_serial_line_oe, .card_presence_in, .card_serial_line_i);

	// ****************************************
	// Helpers
	// ****************************************
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc

	task automatic chk(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Edge counts may be off by one at the window borders
	task automatic chk_cnt(input int got, input int exp);
		cmp_count++;
		if (got < exp - 1 || got > exp + 1) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_cnt

	task automatic count_rises(output int n);
		logic prev;
		n = 0;
		prev = card_clock_out;
		repeat (480) begin
			@(posedge clock);
			if (card_clock_out === 1'b1 && prev === 1'b0) n++;
			prev = card_clock_out;
		end
	endtask : count_rises

	// Address and data are taken at the chip select rise
	task automatic prog(input logic [1:0] addr, input logic [1:0] data);
		@(posedge clock);
		chip_select_n <= 1'b0;
		program_select_n <= 1'b0;
		{program_addr_bit1, program_addr_bit0} <= addr;
		{host_reset_in, host_drv} <= data;
		cyc(5);
		chip_select_n <= 1'b1;
		cyc(1);
		program_select_n <= 1'b1;
		{host_reset_in, host_drv} <= 2'h1;
		cyc(8);
	endtask : prog

	task automatic cs_pulse();
		@(posedge clock);
		chip_select_n <= 1'b0;
		cyc(3);
		chip_select_n <= 1'b1;
		cyc(6);
	endtask : cs_pulse

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_presence();
		chk(interrupt_n_out, 1'b1);
		chk(converter_enable_out, 1'b0);
		chk(status_out, 1'b0);
		chk(card_reset_out, 1'b0);
		inserted <= 1'b1;
		cyc(6);
		chk(interrupt_n_out, 1'b0);
		cs_pulse();
		chk(interrupt_n_out, 1'b1);
		cyc(20);
		chk(interrupt_n_out, 1'b1);
		inserted <= 1'b0;
		cyc(8);
		chk(interrupt_n_out, 1'b1);
		closed_switch <= 1'b1;
		cyc(6);
		prog(ADDR_PRESENCE, 2'h1);
		chk(interrupt_n_out, 1'b1);
		inserted <= 1'b1;
		cyc(6);
		chk(interrupt_n_out, 1'b0);
		chk(status_out, 1'b1);
		$display("done: presence");
	endtask : t_presence

	task automatic t_power_serial();
		chip_select_n <= 1'b0;
		power_request <= 1'b1;
		cyc(8);
		chk(converter_enable_out, 1'b1);
		chk(interrupt_n_out, 1'b1);
		host_reset_in <= 1'b1;
		cyc(6);
		chk(card_reset_out, 1'b1);
		program_select_n <= 1'b0;
		host_reset_in <= 1'b0;
		cyc(6);
		chk(card_reset_out, 1'b1);
		program_select_n <= 1'b1;
		cyc(6);
		chk(card_reset_out, 1'b0);
		host_drv <= 1'b0;
		cyc(6);
		chk(card_serial_line_oe, 1'b1);
		chk(card_serial_line_o, 1'b0);
		chk(host_serial_o, 1'b0);
		chip_select_n <= 1'b1;
		cyc(2);
		host_drv <= 1'b1;
		card_tx_low <= 1'b1;
		cyc(8);
		chk(card_serial_line_oe, 1'b1);
		chk(host_serial_oe, 1'b0);
		chip_select_n <= 1'b0;
		cyc(12);
		chk(host_serial_oe, 1'b1);
		card_tx_low <= 1'b0;
		cyc(12);
		chk(host_serial_oe, 1'b0);
		chk(card_serial_line_oe, 1'b0);
		chip_select_n <= 1'b1;
		cyc(4);
		$display("done: power and serial");
	endtask : t_power_serial

	task automatic t_clock();
		int n;
		for (int d = 0; d < 4; d++) begin
			prog(ADDR_CLOCK_DIV, 2'(d));
			count_rises(n);
			chk_cnt(n, 40 >> d);
		end
		prog(ADDR_CLOCK_PARK, 2'h3);
		count_rises(n);
		chk_cnt(n, 0);
		chk(card_clock_out, 1'b1);
		prog(ADDR_CLOCK_PARK, 2'h1);
		chk(card_clock_out, 1'b0);
		prog(ADDR_CLOCK_PARK, 2'h0);
		count_rises(n);
		chk_cnt(n, 5);
		$display("done: clock");
	endtask : t_clock

	task automatic t_faults();
		prog(ADDR_STATUS_SEL, 2'h3);
		chk(status_out, 1'b1);
		card_supply_low_in <= 1'b1;
		cyc(8);
		chk(status_out, 1'b0);
		chk(converter_enable_out, 1'b1);
		card_supply_low_in <= 1'b0;
		cs_pulse();
		card_supply_overload_in <= 1'b1;
		cyc(6);
		chk(converter_enable_out, 1'b0);
		chk(interrupt_n_out, 1'b0);
		chk(card_reset_out, 1'b0);
		chk(card_clock_out, 1'b0);
		card_supply_overload_in <= 1'b0;
		prog(ADDR_STATUS_SEL, 2'h2);
		chk(status_out, 1'b0);
		chip_select_n <= 1'b0;
		power_request <= 1'b0;
		cyc(6);
		power_request <= 1'b1;
		cyc(8);
		chk(converter_enable_out, 1'b1);
		chk(interrupt_n_out, 1'b1);
		prog(ADDR_STATUS_SEL, 2'h1);
		chk(status_out, 1'b1);
		battery_low_in <= 1'b1;
		cyc(6);
		chk(status_out, 1'b0);
		chk(card_power_down_sequence, 1'b1);
		cyc(400);
		chk(converter_enable_out, 1'b0);
		chk(card_power_down_sequence, 1'b0);
		chk(card_reset_out, 1'b0);
		$display("done: faults");
	endtask : t_faults

	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : final_report

	initial begin
		cyc(10);
		sys_rst <= 1'b0;
		cyc(3);
		t_presence();
		t_power_serial();
		t_clock();
		t_faults();
		final_report();
	end

	// A hang ends the run as a mismatch
	initial begin
		cyc(20000);
		n_fail++;
		$display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
		final_report();
	end
endmodule : smart_card_pin_control_tb_top
